// File: src/fochn_pkg.sv
// Constants shared by the frequency output channel.
// Assumes a single 20 MHz core clock and plain control ports.
//
// Behaviour
// - Running wave frequency follows the setpoint
// - Go echo mirrors the pending go request
// - Role select: plain input or hardware enable
// - Hardware role starts on first sense rise
// - Sense rises ignored while a sequence runs
// - Start runs delay, sets flag, wave after
// - Wave runs endlessly while go stays set
// - Go low aborts; flag and output drop
// - Time base 0.1 ms or 1 ms
// - Hertz format: setpoint is 1 to 5000 Hz
// - Analog format: setpoint/27648 times 5 kHz
// - New setpoint applied at next output rise
// - Frequency accuracy 0.01/0.1/0.5 Hz by band
// - Configured delay is base times count
// - Short interface scales delay by factor/10
// - Isochronous sync changes nothing here
// - Delay under 0.2 ms is zero, capped 65.535 s
// - Setpoint capped at 5000 or 27648

package fochn_pkg;

  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Delay counting runs on a tenth of the time base
  localparam int unsigned UNIT_NS_SHORT = 10_000;
  localparam int unsigned UNIT_NS_LONG = 100_000;
  localparam int unsigned UNIT_CYC_SHORT = UNIT_NS_SHORT * CLK_MHZ / 1000;
  localparam int unsigned UNIT_CYC_LONG = UNIT_NS_LONG * CLK_MHZ / 1000;
  localparam int unsigned DIV_W = 16;

  // ==========================================================
  // Delay limits, in ns, and in delay units per base
  localparam longint unsigned DLY_MIN_NS = 200_000;
  localparam longint unsigned DLY_MAX_NS = 65_535_000_000;
  localparam int unsigned DLY_W = 24;
  localparam logic [DLY_W-1:0] DLY_MIN_SHORT =
    DLY_W'(DLY_MIN_NS / UNIT_NS_SHORT);
  localparam logic [DLY_W-1:0] DLY_MIN_LONG =
    DLY_W'(DLY_MIN_NS / UNIT_NS_LONG);
  localparam logic [DLY_W-1:0] DLY_MAX_SHORT =
    DLY_W'(DLY_MAX_NS / UNIT_NS_SHORT);
  localparam logic [DLY_W-1:0] DLY_MAX_LONG =
    DLY_W'(DLY_MAX_NS / UNIT_NS_LONG);
  localparam logic [DLY_W-1:0] FACTOR_WEIGHT = 24'h00000a;

  // ==========================================================
  // Setpoint formats and phase step scaling (Q16)
  localparam logic [15:0] SP_MAX_HZ = 16'h1388;
  localparam logic [15:0] SP_MAX_AN = 16'h6c00;
  localparam longint unsigned AN_FULL_HZ = 5000;
  localparam longint unsigned AN_FULL_CNT = 27648;
  localparam logic [63:0] K_HZ_Q16 = 64'((64'd1 << 48) / CLK_HZ);
  localparam logic [63:0] K_AN_Q16 =
    64'(((64'd1 << 48) * AN_FULL_HZ) / (AN_FULL_CNT * CLK_HZ));
  localparam int unsigned PH_W = 32;
  localparam logic [PH_W-1:0] PH_HIGH = 32'h80000000;

  // ==========================================================
  // Sequence states
  typedef enum logic [1:0] {
    FOCHN_IDLE = 2'b00,
    FOCHN_DELAY = 2'b01,
    FOCHN_WAVE = 2'b10
  } fochn_state_e;

endpackage

// File: src/fochn_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps

module fochn_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Pin side
  input wire logic pin_in,
  // Core side
  output logic level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once two later stages agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule

// File: src/fochn_top.sv
// Frequency output channel: on-delay, then a square wave.
// Assumes control bits come from logic on core_clk and the
// sense input comes from a pin.
`timescale 1ns/1ps

module fochn_top #(
  parameter int unsigned UNIT_CYC_S = fochn_pkg::UNIT_CYC_SHORT,
  parameter int unsigned UNIT_CYC_L = fochn_pkg::UNIT_CYC_LONG
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control bits
  input wire logic software_go,
  input wire logic forced_output_sel,
  input wire logic [15:0] setpoint,
  input wire logic [7:0] delay_factor,
  input wire logic [15:0] long_delay_count,
  // Configuration
  input wire logic input_role_select,
  input wire logic time_base_long,
  input wire logic format_analog,
  input wire logic long_interface,
  input wire logic [15:0] cfg_delay_count,
  // Pins
  input wire logic sense_input,
  output logic pulse_out,
  // Feedback
  output logic sequence_running_flag,
  output logic go_echo,
  output logic sense_level
);
  import fochn_pkg::*;

  // The divider must tick at most every second cycle and fit its counter
  if (UNIT_CYC_S < 2 || UNIT_CYC_S >= (1 << DIV_W) ||
      UNIT_CYC_L < 2 || UNIT_CYC_L >= (1 << DIV_W)) begin : g_bad_unit
    $error("Delay unit divider out of range");
  end

  // ==========================================================
  // Input capture
  logic sense_sync;
  logic sense_prev_reg;
  logic go_prev_reg;
  logic sense_rise;
  logic go_rise;

  fochn_sync u_sense_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_in(sense_input),
    .level_out(sense_sync)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sense_prev_reg <= 1'b0;
      go_prev_reg <= 1'b0;
    end else begin
      sense_prev_reg <= sense_sync;
      go_prev_reg <= software_go;
    end
  end

  assign sense_rise = sense_sync && !sense_prev_reg;
  // Forced output select blocks the start request
  assign go_rise = software_go && !go_prev_reg && !forced_output_sel;

  // ==========================================================
  // Effective on-delay in tenths of the time base
  logic [DLY_W-1:0] dly_raw;
  logic [DLY_W-1:0] dly_units;
  logic [DLY_W-1:0] dly_min;
  logic [DLY_W-1:0] dly_max;

  always_comb begin
    dly_min = time_base_long ? DLY_MIN_LONG : DLY_MIN_SHORT;
    dly_max = time_base_long ? DLY_MAX_LONG : DLY_MAX_SHORT;
    if (long_interface) begin
      // Count is whole base units, taken from the control word
      dly_raw = DLY_W'(long_delay_count) * FACTOR_WEIGHT;
    end else begin
      // Factor in tenths times configured base count
      dly_raw = DLY_W'(cfg_delay_count) * DLY_W'(delay_factor);
    end
    if (dly_raw < dly_min) begin
      dly_units = '0;
    end else if (dly_raw > dly_max) begin
      dly_units = dly_max;
    end else begin
      dly_units = dly_raw;
    end
  end

  // ==========================================================
  // Setpoint clamp and phase step
  logic [15:0] sp_clamp;
  logic [63:0] step_prod;
  logic [PH_W-1:0] step_calc;

  always_comb begin
    if (format_analog) begin
      sp_clamp = (setpoint > SP_MAX_AN) ? SP_MAX_AN : setpoint;
      step_prod = 64'(setpoint > SP_MAX_AN ? SP_MAX_AN : setpoint) *
                  K_AN_Q16;
    end else begin
      sp_clamp = (setpoint > SP_MAX_HZ) ? SP_MAX_HZ : setpoint;
      step_prod = 64'(setpoint > SP_MAX_HZ ? SP_MAX_HZ : setpoint) *
                  K_HZ_Q16;
    end
    // 32-bit phase gives about 5 mHz steps at 20 MHz
    step_calc = step_prod[PH_W+15:16];
  end

  // ==========================================================
  // Sequence control
  fochn_state_e state_reg;
  logic armed_reg;
  logic start;
  logic delay_done;
  logic [DLY_W-1:0] dly_cnt_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic unit_tick;

  // Hardware role: go arms, first sense rise fires
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_reg <= 1'b0;
    end else if (!software_go || start) begin
      armed_reg <= 1'b0;
    end else if (go_rise) begin
      armed_reg <= 1'b1;
    end
  end

  always_comb begin
    if (state_reg != FOCHN_IDLE || !software_go) begin
      start = 1'b0;
    end else if (input_role_select) begin
      start = (armed_reg || go_rise) && sense_rise;
    end else begin
      start = go_rise;
    end
  end

  // Divider restarts at every start so the delay is exact
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= '0;
    end else if (start || state_reg != FOCHN_DELAY || unit_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  assign unit_tick = (div_cnt_reg == (time_base_long ?
                     DIV_W'(UNIT_CYC_L - 1) : DIV_W'(UNIT_CYC_S - 1)));
  assign delay_done = unit_tick && (dly_cnt_reg == DLY_W'(1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_cnt_reg <= '0;
    end else if (start) begin
      dly_cnt_reg <= dly_units;
    end else if (state_reg == FOCHN_DELAY && unit_tick) begin
      dly_cnt_reg <= dly_cnt_reg - 1'b1;
    end
  end

  // Isochronous cycles do not touch this path at all
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= FOCHN_IDLE;
    end else if (!software_go) begin
      state_reg <= FOCHN_IDLE;
    end else begin
      case (state_reg)
        FOCHN_IDLE: begin
          if (start && dly_units == '0) begin
            state_reg <= FOCHN_WAVE;
          end else if (start) begin
            state_reg <= FOCHN_DELAY;
          end
        end
        FOCHN_DELAY: begin
          if (delay_done) begin
            state_reg <= FOCHN_WAVE;
          end
        end
        FOCHN_WAVE: begin
          state_reg <= FOCHN_WAVE;
        end
        default: begin
          state_reg <= FOCHN_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Square wave generator
  logic [PH_W-1:0] phase_reg;
  logic [PH_W-1:0] phase_next;
  logic [PH_W-1:0] step_reg;
  logic wave_rise;
  logic wave_start;

  assign wave_start = software_go &&
    ((state_reg == FOCHN_IDLE && start && dly_units == '0) ||
     (state_reg == FOCHN_DELAY && delay_done));
  assign phase_next = phase_reg + step_reg;
  assign wave_rise = !phase_reg[PH_W-1] && phase_next[PH_W-1];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= '0;
      step_reg <= '0;
    end else if (wave_start) begin
      // Wave opens on a rising edge with the current setpoint
      phase_reg <= PH_HIGH;
      step_reg <= step_calc;
    end else if (state_reg == FOCHN_WAVE && software_go) begin
      phase_reg <= phase_next;
      if (wave_rise) begin
        step_reg <= step_calc;
      end
    end else begin
      phase_reg <= '0;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_out <= 1'b0;
      sequence_running_flag <= 1'b0;
    end else if (!software_go) begin
      pulse_out <= 1'b0;
      sequence_running_flag <= 1'b0;
    end else begin
      if (wave_start) begin
        pulse_out <= 1'b1;
      end else if (state_reg == FOCHN_WAVE) begin
        pulse_out <= phase_next[PH_W-1];
      end else begin
        pulse_out <= 1'b0;
      end
      if (start) begin
        sequence_running_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      go_echo <= 1'b0;
      sense_level <= 1'b0;
    end else begin
      go_echo <= software_go;
      sense_level <= sense_sync;
    end
  end

  // ==========================================================
  // Checks
  a_go_echo_follows: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ##1 go_echo == $past(software_go))
    else $error("go echo does not follow go");

  a_abort_clears: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !software_go |=> !sequence_running_flag && !pulse_out)
    else $error("go low did not abort sequence");

  a_plain_start: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !input_role_select && go_rise && state_reg == FOCHN_IDLE
    |=> sequence_running_flag)
    else $error("plain role start did not set running");

  a_zero_delay_high: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    start && dly_units == '0 |=> pulse_out && state_reg == FOCHN_WAVE)
    else $error("zero delay start not high");

  a_delay_low: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    start && dly_units != '0 |=> !pulse_out ##0
    state_reg == FOCHN_DELAY)
    else $error("delayed start not low");

  a_hw_edge_ignored: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    state_reg == FOCHN_WAVE && sense_rise && software_go
    |=> state_reg == FOCHN_WAVE && $stable(step_reg) || $past(wave_rise))
    else $error("sense edge disturbed running sequence");

  a_hw_rise_ignored: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    state_reg == FOCHN_DELAY && sense_rise && software_go
    |=> dly_cnt_reg <= $past(dly_cnt_reg))
    else $error("sense edge reloaded on-delay");

  a_forced_blocks: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !input_role_select && forced_output_sel && state_reg == FOCHN_IDLE
    |=> !sequence_running_flag)
    else $error("forced output select did not block start");

  a_delay_quiet: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    state_reg == FOCHN_DELAY && software_go && !delay_done
    |=> !pulse_out)
    else $error("output high before delay end");

  a_step_held: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    state_reg == FOCHN_WAVE && software_go && !wave_rise
    |=> $stable(step_reg))
    else $error("step changed mid period");

  a_setpoint_cap: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    sp_clamp <= (format_analog ? SP_MAX_AN : SP_MAX_HZ))
    else $error("setpoint exceeds cap");

  a_delay_cap: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    dly_units == '0 || (dly_units >= dly_min && dly_units <= dly_max))
    else $error("delay outside limits");

  a_hw_needs_edge: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    input_role_select && state_reg == FOCHN_IDLE && !sense_rise
    |=> !sequence_running_flag)
    else $error("hardware role started without edge");

  c_plain_start: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    !input_role_select && start);
  c_hw_start: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    input_role_select && start && !go_rise);
  c_abort_in_delay: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    state_reg == FOCHN_DELAY && !software_go);
  c_step_update: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    wave_rise && state_reg == FOCHN_WAVE && step_calc != step_reg);

endmodule

// File: test/fochn_field.sv
// Field wiring model: a contact on the sense pin, a meter on
// the pulse output. Assumes pulse_out is registered on core_clk.
`timescale 1ns/1ps

module fochn_field (
  // Clock
  input wire logic core_clk,
  // Pins
  input wire logic pulse_out,
  output logic sense_input,
  // Bench side
  input wire logic hw_fire,
  input wire logic clr,
  output int rises,
  output int period
);
  int cyc;
  int t_rise;
  logic last;

  // ==========================================================
  // Contact
  // The edge lands between clock edges, as a real switch would
  assign #7 sense_input = hw_fire;

  // ==========================================================
  // Meter
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    last <= pulse_out;
    if (clr) begin
      rises <= 0;
    end else if (pulse_out === 1'b1 && last === 1'b0) begin
      rises <= rises + 1;
      period <= cyc - t_rise;
      t_rise <= cyc;
    end
  end
endmodule

// File: test/test_fochn_top.sv
// Self-checking bench for the frequency output channel.
// Assumes fochn_field stands at the pins; delay units shortened.
`timescale 1ns/1ps

module test_fochn_top;
  typedef struct {
    logic fa;
    logic [15:0] sp;
    logic lng;
    logic tbl;
    logic [15:0] cfg;
    logic [7:0] fac;
    logic [15:0] lc;
    int dly;
    int per;
  } fochn_row_s;
  // dly: cycles from go high to output high; per: 0 skips the meter
  fochn_row_s rows [13] = '{
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000, 1, 4000},
    '{1'b0, 16'hffff, 1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000, 1, 4000},
    '{1'b1, 16'h6c00, 1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000, 1, 4000},
    '{1'b1, 16'hffff, 1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000, 1, 4000},
    '{1'b1, 16'h5100, 1'b0, 1'b0, 16'h0000, 8'h00, 16'h0000, 1, 5333},
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0005, 8'h0a, 16'h0000, 201, 0},
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0001, 8'h0a, 16'h0000, 1, 0},
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0064, 8'h00, 16'h0000, 1, 0},
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0002, 8'h0a, 16'h0000, 81, 0},
    '{1'b0, 16'h1388, 1'b0, 1'b0, 16'h0013, 8'h01, 16'h0000, 1, 0},
    '{1'b0, 16'h1388, 1'b1, 1'b1, 16'h0000, 8'h00, 16'h0003, 241, 0},
    '{1'b0, 16'h1388, 1'b1, 1'b0, 16'h0000, 8'h00, 16'h0001, 1, 0},
    '{1'b0, 16'h1388, 1'b0, 1'b1, 16'h0002, 8'h0a, 16'h0000, 161, 0}
  };
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic software_go = 1'b0;
  logic forced_output_sel = 1'b0;
  logic input_role_select = 1'b0;
  logic hw_fire = 1'b0;
  logic clr = 1'b0;
  logic sense_input, pulse_out, flag, go_echo, sense_level;
  fochn_row_s r;
  int rises, period, n, cycles, n_mismatch, num_checks;

  always #25 core_clk = ~core_clk;

  fochn_top #(.UNIT_CYC_S(4), .UNIT_CYC_L(8)) dut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .software_go(software_go),
    .forced_output_sel(forced_output_sel),
    .setpoint(r.sp),
    .delay_factor(r.fac),
    .long_delay_count(r.lc),
    .input_role_select(input_role_select),
    .time_base_long(r.tbl),
    .format_analog(r.fa),
    .long_interface(r.lng),
    .cfg_delay_count(r.cfg),
    .sense_input(sense_input),
    .pulse_out(pulse_out),
    .sequence_running_flag(flag),
    .go_echo(go_echo),
    .sense_level(sense_level)
  );

  fochn_field field (
    .core_clk(core_clk),
    .pulse_out(pulse_out),
    .sense_input(sense_input),
    .hw_fire(hw_fire),
    .clr(clr),
    .rises(rises),
    .period(period)
  );

  // ==========================================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask

  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi,
    input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
        hi, got);
    end
  endtask

  task automatic wait_hi();
    n = 0;
    while (pulse_out !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
  endtask

  // Bounded by n, which the caller clears
  task automatic wait_rises(input int k);
    while (rises < k && n < 40000) begin
      tick(1);
      n++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    r = rows[0];
    tick(8);
    chk_bit("reset outputs", 1'b0, pulse_out | flag | go_echo);
    arst_n = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      r = rows[i];
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      software_go = 1'b1;
      wait_hi();
      chk_rng("on delay", r.dly, r.dly + 2, n);
      chk_bit("running", 1'b1, flag);
      if (r.per > 0) begin
        n = 0;
        wait_rises(3);
        chk_rng("period", r.per - 2, r.per + 2, period);
      end
      software_go = 1'b0;
      tick(1);
      chk_bit("abort in wave", 1'b0, pulse_out | flag);
    end
    // Forced output blocks a start; the echo still follows go
    r = rows[5];
    forced_output_sel = 1'b1;
    software_go = 1'b1;
    chk_bit("echo early", 1'b0, go_echo);
    tick(1);
    chk_bit("echo", 1'b1, go_echo);
    tick(20);
    chk_bit("forced go", 1'b0, flag);
    software_go = 1'b0;
    forced_output_sel = 1'b0;
    tick(1);
    chk_bit("echo off", 1'b0, go_echo);
    software_go = 1'b1;
    tick(50);
    chk_bit("delay flag", 1'b1, flag);
    chk_bit("delay output", 1'b0, pulse_out);
    software_go = 1'b0;
    tick(1);
    chk_bit("abort in delay", 1'b0, flag | pulse_out);
    tick(300);
    chk_bit("no restart", 1'b0, pulse_out);
    // Hardware role: a second contact rise mid-delay must not restart
    input_role_select = 1'b1;
    software_go = 1'b1;
    tick(20);
    chk_bit("armed only", 1'b0, flag);
    n = 0;
    while (pulse_out !== 1'b1 && n < 2000) begin
      hw_fire = n < 80 || n >= 100;
      tick(1);
      n++;
    end
    chk_rng("hw start", 204, 209, n);
    chk_bit("sense seen", 1'b1, sense_level);
    // A contact bounce while the wave runs must leave it alone
    hw_fire = 1'b0;
    tick(10);
    hw_fire = 1'b1;
    tick(10);
    chk_bit("edge in wave", 1'b1, flag);
    software_go = 1'b0;
    hw_fire = 1'b0;
    input_role_select = 1'b0;
    // New setpoint written mid-period
    r = rows[0];
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    software_go = 1'b1;
    n = 0;
    wait_rises(2);
    tick(1000);
    r.sp = 16'h09c4;
    wait_rises(3);
    chk_rng("old period", 3998, 4002, period);
    wait_rises(4);
    chk_rng("new period", 7998, 8002, period);
    arst_n = 1'b0;
    #1;
    chk_bit("reset cut", 1'b0, pulse_out | flag | go_echo);
    software_go = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(2);
    report_and_stop();
  end
endmodule
